// ---- nvm_crc8_regs.svh ----
// constants for the calibration memory crc checker
`ifndef NVM_CRC8_REGS_SVH
`define NVM_CRC8_REGS_SVH
`define CRC_WIDTH      8
`define CRC_POLY       8'h31
`define CRC_INIT       8'h00
`define CRC_FINAL_XOR  8'h00
`define CRC_GOOD       8'h00
`define NVM_BITS       256
`define NVM_WORD_W     16
`define NVM_WORDS      16
`define NVM_ADDR_W     4
`define BYTE_BITS      8
`define BIT_CNT_W      3
`endif

// ---- nvm_crc8_pkg.sv ----
// types for the calibration memory crc checker
package nvm_crc8_pkg;
    typedef struct packed {
        logic       done;
        logic       pass;
        logic [7:0] crc;
    } crc_result_t;
    typedef struct packed {
        logic       rd;
        logic [3:0] addr;
    } nvm_req_t;
endpackage

// ---- crc8_byte_step.sv ----
// one byte step of the crc-8 engine, one bit per clock, msb first
`timescale 1ns/1ns
`include "nvm_crc8_regs.svh"
module crc8_byte_step #(
    parameter logic [7:0] POLY = `CRC_POLY
) (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       start_in,
    input  wire logic [7:0] data_in,
    input  wire logic [7:0] rem_in,
    output logic            busy_out,
    output logic            done_out,
    output logic [7:0]      rem_out
);
    logic [7:0] dat;
    logic [7:0] rem;
    logic [2:0] cnt;
    logic       busy;
    logic       done;
    wire        bits_differ;
    wire  [7:0] next_rem;

    // compare top bits, shift both, fold in polynomial when they differ
    assign bits_differ = dat[7] ^ rem[7];
    assign next_rem    = {rem[6:0], 1'b0} ^ (bits_differ ? POLY : 8'h00);

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            dat  <= 8'h00;
            rem  <= 8'h00;
            cnt  <= 3'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start_in && !busy) begin
            dat  <= data_in;
            rem  <= rem_in;
            cnt  <= 3'h0;
            busy <= 1'b1;
            done <= 1'b0;
        end else if (busy) begin
            dat  <= {dat[6:0], 1'b0};
            rem  <= next_rem;
            cnt  <= cnt + 3'h1;
            busy <= (cnt != 3'h7);
            done <= (cnt == 3'h7);
        end else begin
            done <= 1'b0;
        end
    end

    assign busy_out = busy;
    assign done_out = done;
    assign rem_out  = rem;
endmodule // crc8_byte_step

// ---- nvm_crc8_checker.sv ----
// calibration memory integrity checker: walks the memory and checks crc-8
`timescale 1ns/1ns
`include "nvm_crc8_regs.svh"
module nvm_crc8_checker #(
    parameter int NVM_WORDS = `NVM_WORDS
) (
    input  wire logic                      clk_in,
    input  wire logic                      reset_n_in,
    input  wire logic                      check_start_in,
    input  wire logic                      ext_byte_valid_in,
    input  wire logic [7:0]                ext_byte_in,
    input  wire logic                      ext_clear_in,
    input  wire logic [`NVM_WORD_W-1:0]    nvm_data_in,
    output nvm_crc8_pkg::nvm_req_t         nvm_req_out,
    output nvm_crc8_pkg::crc_result_t      result_out,
    output logic                           busy_out,
    output logic [7:0]                     ext_crc_out
);
    import nvm_crc8_pkg::*;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {IDLE, READ, HIGH, LOW, FINISH} state_t;

    state_t      state;
    state_t      next_state;
    logic [3:0]  addr;
    logic [15:0] word;
    logic [7:0]  run_rem;
    logic        pass;
    logic        done;
    logic        step_start;
    logic [7:0]  step_data;
    logic        step_busy;
    logic        step_done;
    logic [7:0]  step_rem;
    logic        ext_mode;
    logic [7:0]  ext_rem;
    wire         last_word;
    wire         step_idle;
    wire         check_go;
    wire         ext_take;

    assign last_word = (addr == 4'(NVM_WORDS - 1));

    // next state: walk the words, high byte then low byte
    always_comb begin
        next_state = state;
        case (state)
            IDLE: begin
                if (check_go) begin
                    next_state = READ;
                end
            end
            READ: begin
                next_state = HIGH;
            end
            HIGH: begin
                if (step_done) begin
                    next_state = LOW;
                end
            end
            LOW: begin
                if (step_done) begin
                    next_state = last_word ? FINISH : READ;
                end
            end
            default: begin
                next_state = IDLE;
            end
        endcase
    end

    // a check start is refused while an external step drains, so the walk never
    // takes that step's done as its own
    assign step_idle  = !step_busy && !step_done;
    assign check_go   = check_start_in && step_idle;
    // external bytes are refused while a step runs or finishes: a byte taken
    // in the done cycle would start from a stale remainder
    assign ext_take   = ext_byte_valid_in && (state == IDLE) && step_idle && !check_start_in;
    // start a byte step on entry to each byte state
    assign step_start = ((state == HIGH) || (state == LOW)) && step_idle
                        ? 1'b1 : ext_take;
    assign step_data  = (state == HIGH) ? word[15:8] :
                        (state == LOW)  ? word[7:0]  : ext_byte_in;
    assign ext_mode   = (state == IDLE);

    // ----------------------------------------------------------------
    // byte step engine
    // ----------------------------------------------------------------
    crc8_byte_step #(
        .POLY (`CRC_POLY)
    ) u_step (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .start_in   (step_start),
        .data_in    (step_data),
        .rem_in     (ext_mode ? ext_rem : run_rem),
        .busy_out   (step_busy),
        .done_out   (step_done),
        .rem_out    (step_rem)
    );

    // ----------------------------------------------------------------
    // state, word latch and remainders
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state   <= IDLE;
            addr    <= 4'h0;
            word    <= 16'h0000;
            run_rem <= `CRC_INIT;
            pass    <= 1'b0;
            done    <= 1'b0;
            ext_rem <= `CRC_INIT;
        end else begin
            state <= next_state;
            if (state == IDLE && check_go) begin
                addr    <= 4'h0;
                run_rem <= `CRC_INIT;
                done    <= 1'b0;
            end
            if (state == READ) begin
                word <= nvm_data_in;
            end
            if ((state == HIGH || state == LOW) && step_done) begin
                run_rem <= step_rem;
            end
            if (state == LOW && step_done && !last_word) begin
                addr <= addr + 4'h1;
            end
            if (state == FINISH) begin
                done <= 1'b1;
                pass <= ((run_rem ^ `CRC_FINAL_XOR) == `CRC_GOOD);
            end
            if (ext_clear_in) begin
                ext_rem <= `CRC_INIT;
            end else if (ext_mode && step_done) begin
                ext_rem <= step_rem;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign nvm_req_out.rd   = (state == READ);
    assign nvm_req_out.addr = addr;
    assign result_out.done  = done;
    assign result_out.pass  = pass;
    assign result_out.crc   = run_rem;
    assign busy_out         = (state != IDLE) || step_busy || step_done;
    assign ext_crc_out      = ext_rem;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_low_end;
        state == LOW && step_done;
    endsequence

    // one byte step: eight shifting cycles, then one cycle of done
    sequence s_step_run;
        step_busy [*8] ##1 (!step_busy && step_done);
    endsequence

    a_poly_step_len: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(step_busy) |-> s_step_run)
        else $error("byte step not eight cycles");
    a_word_walk: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        nvm_req_out.rd |=> !step_busy ##1 s_step_run ##1 (state == LOW && !step_busy)
        ##1 s_step_run)
        else $error("word walk out of step");
    a_high_then_low: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state == HIGH && step_done |=> state == LOW)
        else $error("low byte did not follow high byte");
    a_chain_rem: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (state == HIGH || state == LOW) && step_done |=> run_rem == $past(step_rem))
        else $error("remainder not chained");
    a_addr_advance: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_low_end and !last_word |=> addr == $past(addr) + 4'h1)
        else $error("address did not advance");
    a_last_finish: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_low_end and last_word |=> state == FINISH ##1 done)
        else $error("finish missed after last word");
    a_pass_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state == FINISH |=> pass == ($past(run_rem) == 8'h00))
        else $error("pass flag wrong");
    a_start_init: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state == IDLE && check_go |=> run_rem == 8'h00 && addr == 4'h0)
        else $error("check not initialised");
    a_read_strobe: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        nvm_req_out.rd |=> state == HIGH ##1 step_busy)
        else $error("byte step not started after read");
    a_ext_chain: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ext_mode && step_done && !ext_clear_in |=> ext_crc_out == $past(step_rem))
        else $error("external remainder not chained");

    a_start_held: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state == IDLE && check_start_in && !step_idle |=> state == IDLE)
        else $error("check started over a running byte step");
    a_ext_refused: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state == IDLE && ext_byte_valid_in && step_done |=> !step_busy)
        else $error("byte taken in the done cycle");
    a_done_stands: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        done && !(state == IDLE && check_go) |=> done)
        else $error("done dropped before next check");
    a_pass_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state != FINISH |=> $stable(pass))
        else $error("pass changed outside finish");
    a_rd_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        nvm_req_out.rd |=> !nvm_req_out.rd)
        else $error("read strobe longer than one cycle");
endmodule // nvm_crc8_checker

// ---- nvm_model.sv ----
// calibration memory model: combinational read of sixteen words
`timescale 1ns/1ns
module nvm_model #(
    parameter logic [255:0] IMAGE = 256'h0
) (
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic        flip_in,
    output logic      [15:0] data_out
);
    logic [15:0] word;
    logic [15:0] last = 16'h0000;
    // flip_in spoils one bit of word 4 to give a bad image
    assign word = IMAGE[255 - 16 * addr_in -: 16] ^ {15'h0, flip_in && addr_in == 4'h4};
    // outside a read the bus shows the inverse of the last word
    assign data_out = rd_in ? word : ~last;
    always @(posedge clk_in) begin
        if (rd_in) last <= word;
    end
endmodule // nvm_model

// ---- tb_nvm_crc8_checker.sv ----
// self-checking bench for the calibration memory crc checker
`timescale 1ns/1ns
module tb_nvm_crc8_checker;
    import nvm_crc8_pkg::*;
    localparam logic [255:0] IMAGE = {16'h00cf, 16'h0300, 16'h0000, 16'h0001, 16'h4513,
        16'h3d08, 16'h1c1a, 16'h3c91, 16'h968a, 16'h4ead, 16'h63d7, 16'h4ebc, 16'h61c3,
        16'h3026, 16'h0000, 16'h0139};
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        check_start_in = 1'b0;
    logic        ext_byte_valid_in = 1'b0;
    logic [7:0]  ext_byte_in = 8'h00;
    logic        ext_clear_in = 1'b0;
    logic        flip = 1'b0;
    logic [15:0] nvm_data;
    nvm_req_t    nvm_req;
    crc_result_t result;
    logic        busy;
    logic [7:0]  ext_crc;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    int          nreads = 0;

    nvm_crc8_checker DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .check_start_in(check_start_in), .ext_byte_valid_in(ext_byte_valid_in),
        .ext_byte_in(ext_byte_in), .ext_clear_in(ext_clear_in), .nvm_data_in(nvm_data),
        .nvm_req_out(nvm_req), .result_out(result), .busy_out(busy), .ext_crc_out(ext_crc));
    nvm_model #(.IMAGE(IMAGE)) mem (.clk_in(clk_in), .rd_in(nvm_req.rd),
        .addr_in(nvm_req.addr), .flip_in(flip), .data_out(nvm_data));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    function automatic logic [7:0] crc_byte(input logic [7:0] d, input logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            r = (r[7] != d[i]) ? {r[6:0], 1'b0} ^ 8'h31 : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    function automatic logic [7:0] image_crc(input logic f);
        logic [15:0] w;
        logic [7:0]  r;
        r = 8'h00;
        for (int a = 0; a < 16; a++) begin
            w = IMAGE[255 - 16 * a -: 16] ^ {15'h0, f && a == 4};
            r = crc_byte(w[7:0], crc_byte(w[15:8], r));
        end
        return r;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("errors %0d, comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // reads must walk the words in ascending order
    always @(negedge clk_in) begin
        if (nvm_req.rd === 1'b1) begin
            check({4'h0, nvm_req.addr}, nreads[7:0]);
            nreads++;
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic send_byte(input logic [7:0] b, input logic [7:0] exp);
        @(negedge clk_in);
        ext_byte_in = b;
        ext_byte_valid_in = 1'b1;
        @(negedge clk_in);
        ext_byte_valid_in = 1'b0;
        repeat (10) @(negedge clk_in);
        check(ext_crc, exp);
    endtask

    // a byte and a check start offered as a step completes are refused
    task automatic test_busy_ext;
        @(negedge clk_in);
        ext_byte_in = 8'h55;
        ext_byte_valid_in = 1'b1;
        @(negedge clk_in);
        ext_byte_valid_in = 1'b0;
        repeat (8) @(negedge clk_in);
        check({7'h0, busy}, 8'h01);
        ext_byte_in = 8'haa;
        ext_byte_valid_in = 1'b1;
        check_start_in = 1'b1;
        @(negedge clk_in);
        ext_byte_valid_in = 1'b0;
        check_start_in = 1'b0;
        @(negedge clk_in);
        check({7'h0, busy}, 8'h00);
        repeat (10) @(negedge clk_in);
        check(ext_crc, crc_byte(8'h55, 8'h69));
    endtask

    // a clear arriving with a byte completion wins
    task automatic test_clear_race;
        @(negedge clk_in);
        ext_byte_in = 8'h77;
        ext_byte_valid_in = 1'b1;
        @(negedge clk_in);
        ext_byte_valid_in = 1'b0;
        repeat (8) @(negedge clk_in);
        ext_clear_in = 1'b1;
        @(negedge clk_in);
        ext_clear_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check(ext_crc, 8'h00);
    endtask

    task automatic test_ext;
        send_byte(8'hcf, 8'h69);
        test_busy_ext();
        @(negedge clk_in);
        ext_clear_in = 1'b1;
        @(negedge clk_in);
        ext_clear_in = 1'b0;
        check(ext_crc, 8'h00);
        test_clear_race();
        send_byte(8'hbe, crc_byte(8'hbe, 8'h00));
        send_byte(8'hef, 8'h13);
    endtask

    task automatic run_check(input logic f, input logic poke);
        @(negedge clk_in);
        flip = f;
        nreads = 0;
        check_start_in = 1'b1;
        @(negedge clk_in);
        check_start_in = 1'b0;
        repeat (40) @(negedge clk_in);
        check({7'h0, result.done}, 8'h00);
        // a byte and a second start offered mid-check must be dropped
        if (poke) begin
            ext_byte_in = 8'h55;
            ext_byte_valid_in = 1'b1;
            check_start_in = 1'b1;
            @(negedge clk_in);
            ext_byte_valid_in = 1'b0;
            check_start_in = 1'b0;
        end
        for (int i = 0; i < 500 && result.done !== 1'b1; i++) @(negedge clk_in);
        check({7'h0, result.done}, 8'h01);
        check({7'h0, result.pass}, {7'h0, !f});
        check(result.crc, image_crc(f));
        check(nreads[7:0], 8'd16);
        check(ext_crc, 8'h13);
        check({7'h0, busy}, 8'h00);
    endtask

    initial begin
        repeat (20) @(negedge clk_in);
        check({7'h0, result.done}, 8'h00);
        check(ext_crc, 8'h00);
        reset_n_in = 1'b1;
        test_ext();
        run_check(1'b0, 1'b0);
        run_check(1'b1, 1'b1);
        report_and_stop();
    end
endmodule // tb_nvm_crc8_checker
